//--- rtl/diff_line_out.v
// Differential pair driver for the serial line
`timescale 1ns/10ps

module diff_line_out (
    // Clock and reset
    input wire clk_in,
    input wire rstn_in,
    input wire ce_in,
    // Data and enable
    input wire bit_in,
    input wire en_in,
    // Pair
    output reg wire_a_out,
    output reg wire_b_out,
    output reg pair_oe_out
);

// ==========================================
// Registered pair, idle drives a one
always @(posedge clk_in) begin
    if (!rstn_in) begin
        wire_a_out <= 1'b1;
        wire_b_out <= 1'b0;
        pair_oe_out <= 1'b0;
    end else if (ce_in) begin
        wire_a_out <= bit_in; // see [R15]
        wire_b_out <= ~bit_in; // see [R15]
        pair_oe_out <= en_in;
    end
end

endmodule // diff_line_out

//--- rtl/xcvr_dir_ctrl.v
// Transceiver direction control for a differential serial port
// Contract
// [R1] Exactly four modes: four-wire, DTR echo, DTR controlled, auto transmit-ready.
// [R2] Four-wire mode keeps driver and receiver always enabled.
// [R3] Default mode after reset is four-wire.
// [R4] DTR modes: driver off while DTR asserted, on while deasserted.
// [R5] DTR echo mode keeps receiver always enabled, own bytes echo back.
// [R6] Software clears DTR before sending, sets it after last bit leaves.
// [R7] DTR controlled mode disables receiver whenever driver is enabled.
// [R8] DTR controlled mode enables receiver exactly when DTR asserted.
// [R9] Auto mode: driver on while transmit-ready asserted, receiver otherwise.
// [R10] Auto mode enables driver per byte without software action.
// [R11] Auto mode disables receiver whenever driver is enabled.
// [R12] DTR and transmit-ready are active low.
// [R13] Stored mode is applied to the enables when the port opens.
// [R14] Codes 128, 129, 130, 131 select the four modes.
// [R15] Logic one drives wire A above B, zero drives A below B.
// [R16] Mode changes take effect only between characters.
`timescale 1ns/10ps
`include "xcvr_dir_defs.vh"

module xcvr_dir_ctrl (
    // Clock, reset, enable
    input wire clk_in,
    input wire rstn_in,
    input wire ce_in,
    // Configuration
    input wire [`MODE_W-1:0] mode_code_in,
    input wire mode_wr_in,
    input wire port_open_in,
    // UART side
    input wire dtr_n_in,
    input wire transmit_slot_ready_n_in,
    input wire tx_busy_in,
    input wire txd_in,
    // Line receiver
    input wire rx_line_in,
    // Status
    output reg [`MODE_W-1:0] mode_stored_out,
    output reg [1:0] mode_active_out,
    output reg mode_code_err_out,
    // Line side
    output reg drv_en_out,
    output reg rcv_en_out,
    output reg rxd_out,
    output wire line_a_out,
    output wire line_b_out,
    output wire line_oe_out
);

// ==========================================
// Code decode, used for write check and apply
function [2:0] decode_mode;
    input [`MODE_W-1:0] code;
    begin
        case (code)
            `MODE_FOUR_WIRE: decode_mode = {1'b1, `IDX_FOUR}; // see [R14]
            `MODE_DTR_ECHO: decode_mode = {1'b1, `IDX_ECHO}; // see [R14]
            `MODE_DTR_CTRL: decode_mode = {1'b1, `IDX_CTRL}; // see [R14]
            `MODE_AUTO_TX: decode_mode = {1'b1, `IDX_AUTO}; // see [R14]
            default: decode_mode = {1'b0, `IDX_FOUR}; // see [R1]
        endcase
    end
endfunction

// ==========================================
// Apply control states
localparam APPLY_IDLE = 1'b0;
localparam APPLY_WAIT = 1'b1;

reg open_q;
reg apply_q;
reg apply_d;
reg apply_now;
wire [2:0] wr_dec;
wire [2:0] st_dec;
wire open_rise;
wire idle;
wire dtr_asserted;
wire slot_asserted;

assign wr_dec = decode_mode(mode_code_in);
assign st_dec = decode_mode(mode_stored_out);
assign open_rise = port_open_in & ~open_q;
// Stalling the switch while a character is out avoids a truncated byte
assign idle = ~tx_busy_in;
assign dtr_asserted = ~dtr_n_in; // see [R12]
assign slot_asserted = ~transmit_slot_ready_n_in; // see [R12]

// ==========================================
// Port open edge
always @(posedge clk_in) begin
    if (!rstn_in) begin
        open_q <= 1'b0;
    end else if (ce_in) begin
        open_q <= port_open_in;
    end
end

// ==========================================
// Apply sequencing, an open seen mid-character waits for idle
always @* begin
    apply_d = apply_q;
    apply_now = 1'b0;
    case (apply_q)
        APPLY_IDLE: begin
            if (open_rise) begin
                if (idle) begin
                    apply_now = 1'b1; // see [R13]
                end else begin
                    apply_d = APPLY_WAIT; // see [R16]
                end
            end
        end
        APPLY_WAIT: begin
            if (idle) begin
                apply_now = 1'b1; // see [R13] see [R16]
                apply_d = APPLY_IDLE;
            end
        end
        default: begin
            apply_d = APPLY_IDLE;
        end
    endcase
end

always @(posedge clk_in) begin
    if (!rstn_in) begin
        apply_q <= APPLY_IDLE;
    end else if (ce_in) begin
        apply_q <= apply_d;
    end
end

// ==========================================
// Stored selection, invalid codes are refused and the old mode stays
always @(posedge clk_in) begin
    if (!rstn_in) begin
        mode_stored_out <= `MODE_RESET; // see [R3]
        mode_code_err_out <= 1'b0;
    end else if (ce_in) begin
        if (mode_wr_in) begin
            mode_code_err_out <= ~wr_dec[2]; // see [R1]
            if (wr_dec[2]) begin
                mode_stored_out <= mode_code_in; // see [R14]
            end
        end
    end
end

// ==========================================
// Applied mode
always @(posedge clk_in) begin
    if (!rstn_in) begin
        mode_active_out <= `IDX_FOUR; // see [R3]
    end else if (ce_in) begin
        if (apply_now) begin
            mode_active_out <= st_dec[1:0]; // see [R13]
        end
    end
end

// ==========================================
// Enable selection per mode
reg drv_en_d;
reg rcv_en_d;
always @* begin
    drv_en_d = 1'b1;
    rcv_en_d = 1'b1;
    case (mode_active_out)
        `IDX_FOUR: begin
            drv_en_d = 1'b1; // see [R2]
            rcv_en_d = 1'b1; // see [R2]
        end
        `IDX_ECHO: begin
            drv_en_d = ~dtr_asserted; // see [R4] see [R6]
            rcv_en_d = 1'b1; // see [R5]
        end
        `IDX_CTRL: begin
            drv_en_d = ~dtr_asserted; // see [R4]
            rcv_en_d = dtr_asserted; // see [R7] see [R8]
        end
        `IDX_AUTO: begin
            drv_en_d = slot_asserted; // see [R9] see [R10]
            rcv_en_d = ~slot_asserted; // see [R9] see [R11]
        end
        default: begin
            drv_en_d = 1'b1;
            rcv_en_d = 1'b1;
        end
    endcase
end

always @(posedge clk_in) begin
    if (!rstn_in) begin
        drv_en_out <= 1'b0;
        rcv_en_out <= 1'b0;
    end else if (ce_in) begin
        drv_en_out <= drv_en_d;
        rcv_en_out <= rcv_en_d;
    end
end

// ==========================================
// Received data
always @(posedge clk_in) begin
    if (!rstn_in) begin
        rxd_out <= 1'b1;
    end else if (ce_in) begin
        // Masked receiver reads as idle mark, so own bytes never come back in muted modes
        rxd_out <= rcv_en_d ? rx_line_in : 1'b1; // see [R7] see [R11]
    end
end

// ==========================================
// Differential pair
diff_line_out u_pair (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .bit_in(txd_in),
    .en_in(drv_en_d),
    .wire_a_out(line_a_out),
    .wire_b_out(line_b_out),
    .pair_oe_out(line_oe_out)
);

endmodule // xcvr_dir_ctrl

//--- rtl/xcvr_dir_defs.vh
// Constants for the transceiver direction control block
`ifndef XCVR_DIR_DEFS_VH
`define XCVR_DIR_DEFS_VH

// ==========================================
// Mode selection codes
`define MODE_W 8
`define MODE_FOUR_WIRE 8'h80
`define MODE_DTR_ECHO 8'h81
`define MODE_DTR_CTRL 8'h82
`define MODE_AUTO_TX 8'h83
`define MODE_RESET `MODE_FOUR_WIRE

// ==========================================
// Internal mode index
`define IDX_FOUR 2'h0
`define IDX_ECHO 2'h1
`define IDX_CTRL 2'h2
`define IDX_AUTO 2'h3

`endif

//--- tb/line_model.sv
// Line, receiver and remote node model
`timescale 1ns/10ps
module line_model (
    // Local pair and remote node
    input wire line_a_in,
    input wire line_b_in,
    input wire line_oe_in,
    input wire remote_en_in,
    input wire remote_bit_in,
    // Receiver output
    output wire rx_line_out
);
    // ======
    // Local driver wins, then remote node, then bias pull-up to one
    assign rx_line_out = line_oe_in ? line_a_in && !line_b_in : remote_en_in ? remote_bit_in : 1'b1;
endmodule // line_model

//--- tb/xcvr_dir_ctrl_tb.sv
// Self-checking bench for the transceiver direction control
`timescale 1ns/10ps
module xcvr_dir_ctrl_tb;
    // ======
    // Stimulus, observed ports, counters
    reg clk_in = 0, rstn_in = 0, wr = 0, open = 0, dtr_n = 1, slot_n = 1, busy = 0, ce = 1, txd = 1;
    reg [7:0] code = 8'h80;
    wire [7:0] stored;
    wire [1:0] act;
    wire err, drv, rcv, rxd, a, b, oe, rx;
    integer n_errors = 0, n_checks = 0;
    always #12.5 clk_in = ~clk_in;
    xcvr_dir_ctrl u_xcvr_dir_ctrl (.clk_in, .rstn_in, .ce_in(ce), .mode_code_in(code), .mode_wr_in(wr),
        .port_open_in(open), .dtr_n_in(dtr_n), .transmit_slot_ready_n_in(slot_n), .tx_busy_in(busy), .txd_in(txd),
        .rx_line_in(rx), .mode_stored_out(stored), .mode_active_out(act), .mode_code_err_out(err), .drv_en_out(drv),
        .rcv_en_out(rcv), .rxd_out(rxd), .line_a_out(a), .line_b_out(b), .line_oe_out(oe));
    // Remote drives zero, so a muted receiver reads as one
    line_model u_line_model (.line_a_in(a), .line_b_in(b), .line_oe_in(oe), .remote_en_in(1'b1),
        .remote_bit_in(1'b0), .rx_line_out(rx));
    task wrap_up;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task cmp(input [7:0] got, input [7:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task tick(input integer n);
        repeat (n) @(negedge clk_in);
    endtask
    task open_mode(input [7:0] c);
        code = c;
        wr = 1;
        tick(1);
        wr = 0;
        open = 1;
        tick(1);
        open = 0;
        tick(1);
    endtask
    task t_reset;
        cmp({drv, rcv, rxd, oe, a, b, act}, 8'h28);
        cmp(stored, 8'h80);
        rstn_in = 1;
        tick(2);
        cmp({4'h0, act, drv, rcv}, 8'h03);
    endtask
    task t_modes;
        integer m, v;
        reg de, re;
        for (m = 0; m < 4; m = m + 1) begin
            open_mode(8'h80 | m[1:0]);
            cmp({6'h0, act}, m[7:0]);
            for (v = 0; v < 2; v = v + 1) begin
                de = m == 0 || (m == 3 ? !v[0] : v[0]);
                re = m < 2 || !de;
                dtr_n = v[0];
                slot_n = v[0];
                txd = !de || v[0];
                tick(2);
                cmp({5'h0, drv, rcv, rxd}, {5'h0, de, re, !re || (de && txd)});
                cmp({5'h0, a, b, oe}, {5'h0, txd, !txd, de});
            end
        end
    endtask
    task t_bad;
        open_mode(8'h84);
        cmp(stored, 8'h83);
        cmp({5'h0, err, act}, 8'h07);
    endtask
    task t_busy;
        busy = 1;
        open_mode(8'h81);
        tick(1);
        cmp({6'h0, act}, 8'h03);
        busy = 0;
        tick(1);
        cmp({5'h0, err, act}, 8'h01);
    endtask
    task t_freeze;
        tick(1);
        ce = 0;
        dtr_n = 0;
        code = 8'h84;
        wr = 1;
        tick(2);
        cmp({5'h0, err, drv, rcv}, 8'h03);
        cmp(stored, 8'h81);
        wr = 0;
        ce = 1;
        tick(2);
        cmp({5'h0, err, drv, rcv}, 8'h01);
    endtask
    task t_midreset;
        rstn_in = 0;
        tick(2);
        t_reset;
    endtask
    // Cycle ceiling cuts a hang short
    initial begin
        repeat (1000) @(posedge clk_in);
        n_errors = n_errors + 1;
        wrap_up;
    end
    initial begin
        repeat (20) @(negedge clk_in);
        t_reset;
        t_modes;
        t_bad;
        t_busy;
        t_freeze;
        t_midreset;
        wrap_up;
    end
endmodule // xcvr_dir_ctrl_tb

//--- tb/xcvr_dir_props.sv
// Checker for the transceiver direction control
`timescale 1ns/10ps
module dir_props (
    // Clock, reset, enable
    input wire clk_in,
    input wire rstn_in,
    input wire ce_in,
    // Watched inputs
    input wire [7:0] mode_code_in,
    input wire mode_wr_in,
    input wire dtr_n_in,
    input wire transmit_slot_ready_n_in,
    input wire tx_busy_in,
    input wire txd_in,
    // Watched outputs
    input wire [7:0] mode_stored_out,
    input wire [1:0] mode_active_out,
    input wire mode_code_err_out,
    input wire drv_en_out,
    input wire rcv_en_out,
    input wire line_a_out,
    input wire line_b_out,
    input wire line_oe_out
);
    // ======
    // Mode steady and clock enabled since last edge, so enables are judged only once settled
    reg [2:0] prev_q;
    wire [1:0] m = mode_active_out;
    wire st = prev_q[2] && prev_q[1:0] == m;
    wire ok = mode_code_in[7:2] == 6'h20;
    always @(posedge clk_in) prev_q <= {rstn_in & ce_in, m};
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    a_four_wire: assert property (st && m == 2'h0 |-> drv_en_out && rcv_en_out) else $error("four");
    a_echo_en: assert property (st && m == 2'h1 |->
        drv_en_out == $past(dtr_n_in) && rcv_en_out) else $error("echo");
    a_ctrl_en: assert property (st && m == 2'h2 |->
        drv_en_out == $past(dtr_n_in) && rcv_en_out != drv_en_out) else $error("ctrl");
    a_auto_en: assert property (st && m == 2'h3 |->
        drv_en_out == !$past(transmit_slot_ready_n_in) && rcv_en_out != drv_en_out) else $error("auto");
    a_pair_pol: assert property (prev_q[2] |->
        line_a_out == $past(txd_in) && line_b_out != line_a_out && line_oe_out == drv_en_out) else $error("pair");
    a_busy_hold: assert property (tx_busy_in |=> $stable(m)) else $error("busy");
    a_store_ok: assert property (ce_in && mode_wr_in && ok |=>
        mode_stored_out == $past(mode_code_in) && !mode_code_err_out) else $error("store");
    a_store_bad: assert property (ce_in && mode_wr_in && !ok |=>
        mode_code_err_out && $stable(mode_stored_out)) else $error("bad");
    a_ce_freeze: assert property (!ce_in |=>
        $stable(m) && $stable(drv_en_out) && $stable(rcv_en_out) && $stable(mode_stored_out)) else $error("freeze");
endmodule // dir_props
bind xcvr_dir_ctrl dir_props u_dir_props (.clk_in, .rstn_in, .ce_in, .mode_code_in, .mode_wr_in, .dtr_n_in,
    .transmit_slot_ready_n_in, .tx_busy_in, .txd_in, .mode_stored_out, .mode_active_out, .mode_code_err_out,
    .drv_en_out, .rcv_en_out, .line_a_out, .line_b_out, .line_oe_out);
